// [include/lti_pkg.sv]
// Package of offsets, fields, reset values and enums for the threshold block
package lti_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] CFG_OFS      = 8'h00;
  localparam logic [7:0] HIGH_LIM_OFS = 8'h04;
  localparam logic [7:0] LOW_LIM_OFS  = 8'h08;
  localparam logic [7:0] ALERT_OFS    = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_CLR_OFS  = 8'h14;
  localparam logic [7:0] IRQ_EN_OFS   = 8'h18;
  localparam logic [7:0] RESULT_OFS   = 8'h1C;

  // Configuration field positions
  localparam int CFG_FC_LSB    = 0;   // Fault count select, two bits
  localparam int CFG_SENSE_BIT = 3;   // Interrupt pin sense select
  localparam int CFG_LATCH_BIT = 4;   // Sticky mode select
  localparam int CFG_UNDER_BIT = 5;   // Under-threshold mark, read only
  localparam int CFG_OVER_BIT  = 6;   // Over-threshold mark, read only
  localparam int CFG_READY_BIT = 7;   // Conversion ready, read only
  localparam int CFG_MODE_LSB  = 9;   // Operating mode, two bits

  // Interrupt status bit positions
  localparam int IRQ_CONV_BIT  = 0;
  localparam int IRQ_OVER_BIT  = 1;
  localparam int IRQ_UNDER_BIT = 2;
  localparam int IRQ_W         = 3;

  // Values after reset
  localparam logic [1:0]  FC_RST       = 2'h0;
  localparam logic        SENSE_RST    = 1'b0;
  localparam logic        LATCH_RST    = 1'b1;
  localparam logic [1:0]  MODE_RST     = 2'h0;
  localparam logic [15:0] HIGH_LIM_RST = 16'hFFFF;
  localparam logic [15:0] LOW_LIM_RST  = 16'h0000;
  localparam logic [2:0]  IRQ_EN_RST   = 3'h0;

  // Codes
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] EOC_TOP_BITS  = 2'h3;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // Consecutive fault counts per select code
  localparam int           FCNT_W      = 4;
  localparam logic [3:0]   FCNT_SEL0   = 4'h1;
  localparam logic [3:0]   FCNT_SEL1   = 4'h2;
  localparam logic [3:0]   FCNT_SEL2   = 4'h4;
  localparam logic [3:0]   FCNT_SEL3   = 4'h8;

  // Reporting personality derived from sticky bit and low-limit top bits
  typedef enum logic [1:0] {
    LTI_TRANSP,
    LTI_LATCHED,
    LTI_EOC_LATCHED,
    LTI_EOC_TRANSP
  } lti_mode_t;

endpackage

// [core/lti_fault_cnt.sv]
// Consecutive fault counters, one per comparison direction
`timescale 1ns/1ps
module lti_fault_cnt (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Conversion events
  input  wire logic       conv_done,
  input  wire logic [1:0] fault,
  input  wire logic [3:0] target,
  // Criterion met on this conversion
  output logic      [1:0] hit
);

  genvar d;

  // Index 0 counts high-side faults, index 1 low-side faults
  generate
    for (d = 0; d < 2; d++) begin : g_dir
      logic [3:0] cnt_r;   // Faults seen in a row
      logic [3:0] cnt_nxt; // Next count

      // Count up on a fault, restart on a clean one; saturate so a
      // lasting fault keeps meeting the criterion on every conversion
      always_comb begin
        cnt_nxt = cnt_r;
        hit[d]  = 1'b0;
        if (conv_done) begin
          if (fault[d]) begin
            cnt_nxt = (cnt_r >= target) ? target : cnt_r + 4'h1;
            hit[d]  = (cnt_nxt >= target);
          end else begin
            cnt_nxt = 4'h0;
          end
        end
      end

      // Count register
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cnt_r <= 4'h0;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
    end
  endgenerate

endmodule

// [core/lti_core.sv]
// Light threshold interrupt logic with AXI4-Lite register slave
`timescale 1ns/1ps
module lti_core (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Conversion results from the front end
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_result,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read channels
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Sensor pins and system interrupt
  output logic             int_pin,
  output logic [1:0]       op_mode,
  output logic             irq
);

  // Configuration state
  logic [1:0]  fc_r, fc_nxt;              // Fault count select
  logic        sense_r, sense_nxt;        // irq_sense_select
  logic        latch_r, latch_nxt;        // Sticky mode select
  logic [1:0]  mode_r, mode_nxt;          // Operating mode
  logic [15:0] high_r, high_nxt;          // High limit
  logic [15:0] low_r, low_nxt;            // Low limit
  logic [15:0] result_r, result_nxt;      // Latest result
  // Reporting state
  logic        over_r, over_nxt;          // over_threshold_mark
  logic        under_r, under_nxt;        // under_threshold_mark
  logic        ready_r, ready_nxt;        // Conversion ready
  logic        active_r, active_nxt;      // Pin state, active or not
  logic        pin_r, pin_nxt;            // Pin level
  // System interrupt state
  logic [2:0]  stat_r, stat_nxt;          // Sticky event bits
  logic [2:0]  en_r, en_nxt;              // Enable mask
  logic        irq_r, irq_nxt;            // Interrupt output
  // Bus state
  logic        aw_held_r, aw_held_nxt;    // Write address taken
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic        w_held_r, w_held_nxt;      // Write data taken
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        awready_r, awready_nxt;
  logic        wready_r, wready_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        arready_r, arready_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  // Decoded events
  logic        wr_fire;                   // Write performed this cycle
  logic        rd_fire;                   // Read address taken
  logic        cfg_rd;                    // Configuration read
  logic        cfg_wr;                    // Configuration write
  logic        cfg_wr_run;                // Write with a running mode
  logic        alert;                     // Alert response honoured
  logic [15:0] wr16;                      // Lane-merged write value
  logic [15:0] cfg_view;                  // Configuration read image
  logic [3:0]  target;                    // Faults needed in a row
  logic [1:0]  fault;                     // Raw comparison per side
  logic [1:0]  hit;                       // Criterion met per side
  lti_pkg::lti_mode_t rep_mode;           // Reporting personality

  // Fault counters
  lti_fault_cnt i_lti_fault_cnt (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .conv_done (conv_done),
    .fault     (fault),
    .target    (target),
    .hit       (hit)
  );

  // Comparisons and mode decode
  always_comb begin
    fault[0] = (conv_result > high_r);
    fault[1] = (conv_result < low_r);
    case (fc_r)
      2'h0:    target = lti_pkg::FCNT_SEL0;
      2'h1:    target = lti_pkg::FCNT_SEL1;
      2'h2:    target = lti_pkg::FCNT_SEL2;
      default: target = lti_pkg::FCNT_SEL3;
    endcase
    // Top two low-limit bits pick end-of-conversion reporting
    if (low_r[15:14] == lti_pkg::EOC_TOP_BITS) begin
      rep_mode = latch_r ? lti_pkg::LTI_EOC_LATCHED
                         : lti_pkg::LTI_EOC_TRANSP;
    end else begin
      rep_mode = latch_r ? lti_pkg::LTI_LATCHED
                         : lti_pkg::LTI_TRANSP;
    end
  end

  // Bus event decode
  always_comb begin
    wr_fire = aw_held_r & w_held_r & ~bvalid_r;
    rd_fire = s_axi_arvalid & arready_r;
    cfg_rd  = rd_fire & (s_axi_araddr == lti_pkg::CFG_OFS);
    cfg_wr  = wr_fire & (awaddr_r == lti_pkg::CFG_OFS);
    wr16[7:0]  = wstrb_r[0] ? wdata_r[7:0]  : 8'h00;
    wr16[15:8] = wstrb_r[1] ? wdata_r[15:8] : 8'h00;
    // Mode field sits in the upper lane; a missing lane keeps it
    cfg_wr_run = cfg_wr & (wstrb_r[1] ? (wr16[10:9] != lti_pkg::MODE_SHUTDOWN)
                                      : (mode_r != lti_pkg::MODE_SHUTDOWN));
    // Transparent reporting does not answer the alert address
    alert = wr_fire & (awaddr_r == lti_pkg::ALERT_OFS) & latch_r;
    cfg_view = 16'h0000;
    cfg_view[lti_pkg::CFG_FC_LSB +: 2]   = fc_r;
    cfg_view[lti_pkg::CFG_SENSE_BIT]     = sense_r;
    cfg_view[lti_pkg::CFG_LATCH_BIT]     = latch_r;
    cfg_view[lti_pkg::CFG_UNDER_BIT]     = under_r;
    cfg_view[lti_pkg::CFG_OVER_BIT]      = over_r;
    cfg_view[lti_pkg::CFG_READY_BIT]     = ready_r;
    cfg_view[lti_pkg::CFG_MODE_LSB +: 2] = mode_r;
  end

  // Register file writes; only byte lanes 0 and 1 carry data
  always_comb begin
    fc_nxt     = fc_r;
    sense_nxt  = sense_r;
    latch_nxt  = latch_r;
    mode_nxt   = mode_r;
    high_nxt   = high_r;
    low_nxt    = low_r;
    en_nxt     = en_r;
    result_nxt = conv_done ? conv_result : result_r;
    if (cfg_wr) begin
      if (wstrb_r[0]) begin
        fc_nxt    = wr16[lti_pkg::CFG_FC_LSB +: 2];
        sense_nxt = wr16[lti_pkg::CFG_SENSE_BIT];
        latch_nxt = wr16[lti_pkg::CFG_LATCH_BIT];
      end
      if (wstrb_r[1]) begin
        mode_nxt = wr16[lti_pkg::CFG_MODE_LSB +: 2];
      end
    end
    if (wr_fire && awaddr_r == lti_pkg::HIGH_LIM_OFS) begin
      if (wstrb_r[0]) high_nxt[7:0]  = wr16[7:0];
      if (wstrb_r[1]) high_nxt[15:8] = wr16[15:8];
    end
    if (wr_fire && awaddr_r == lti_pkg::LOW_LIM_OFS) begin
      if (wstrb_r[0]) low_nxt[7:0]  = wr16[7:0];
      if (wstrb_r[1]) low_nxt[15:8] = wr16[15:8];
    end
    if (wr_fire && awaddr_r == lti_pkg::IRQ_EN_OFS && wstrb_r[0]) begin
      en_nxt = wr16[2:0];
    end
  end

  // Reporting: clears are applied first so a same-cycle set wins
  always_comb begin
    over_nxt   = over_r;
    under_nxt  = under_r;
    active_nxt = active_r;
    // Conversion ready
    ready_nxt = ready_r;
    if (cfg_rd || cfg_wr_run) begin
      ready_nxt = 1'b0;
    end
    if (conv_done) begin
      ready_nxt = 1'b1;
    end
    case (rep_mode)
      lti_pkg::LTI_TRANSP: begin
        // Config accesses leave the comparison image untouched
        if (hit[0]) begin
          over_nxt   = 1'b1;
          under_nxt  = 1'b0;
          active_nxt = 1'b1;
        end else if (hit[1]) begin
          under_nxt  = 1'b1;
          over_nxt   = 1'b0;
          active_nxt = 1'b0;
        end
      end
      lti_pkg::LTI_LATCHED: begin
        if (cfg_rd) begin
          over_nxt   = 1'b0;
          under_nxt  = 1'b0;
          active_nxt = 1'b0;
        end
        if (alert) begin
          active_nxt = 1'b0;
        end
        if (hit[0]) begin
          over_nxt   = 1'b1;
          active_nxt = 1'b1;
        end
        if (hit[1]) begin
          under_nxt  = 1'b1;
          active_nxt = 1'b1;
        end
      end
      lti_pkg::LTI_EOC_LATCHED: begin
        if (cfg_rd) begin
          over_nxt  = 1'b0;
          under_nxt = 1'b0;
        end
        if (cfg_rd || cfg_wr_run || alert) begin
          active_nxt = 1'b0;
        end
        if (hit[0]) begin
          over_nxt = 1'b1;
        end
        if (hit[1]) begin
          under_nxt = 1'b1;
        end
        if (conv_done) begin
          active_nxt = 1'b1;
        end
      end
      lti_pkg::LTI_EOC_TRANSP: begin
        // Alert response has no effect here
        if (cfg_rd || cfg_wr_run) begin
          active_nxt = 1'b0;
        end
        if (hit[0]) begin
          over_nxt  = 1'b1;
          under_nxt = 1'b0;
        end else if (hit[1]) begin
          under_nxt = 1'b1;
          over_nxt  = 1'b0;
        end
        if (conv_done) begin
          active_nxt = 1'b1;
        end
      end
      default: begin
        active_nxt = active_r;
      end
    endcase
    // Dropping the sticky bit hands the pin back to the transparent
    // image, which is how software frees a pin held over from EOC;
    // EOC modes keep their own config-write pin rules
    if (rep_mode == lti_pkg::LTI_LATCHED && cfg_wr && !latch_nxt
        && !conv_done) begin
      active_nxt = over_r;
    end
    // Low when active with sense 0, low when inactive with sense 1
    pin_nxt = ~(active_nxt ^ sense_nxt);
  end

  // System interrupt: sticky status, set beats clear
  always_comb begin
    stat_nxt = stat_r;
    if (wr_fire && awaddr_r == lti_pkg::IRQ_CLR_OFS && wstrb_r[0]) begin
      stat_nxt = stat_r & ~wr16[2:0];
    end
    stat_nxt[lti_pkg::IRQ_CONV_BIT]  = stat_nxt[lti_pkg::IRQ_CONV_BIT]
                                       | conv_done;
    stat_nxt[lti_pkg::IRQ_OVER_BIT]  = stat_nxt[lti_pkg::IRQ_OVER_BIT]
                                       | hit[0];
    stat_nxt[lti_pkg::IRQ_UNDER_BIT] = stat_nxt[lti_pkg::IRQ_UNDER_BIT]
                                       | hit[1];
    irq_nxt = |(stat_nxt & en_nxt);
  end

  // AXI4-Lite handshakes, one write and one read in flight
  always_comb begin
    aw_held_nxt = aw_held_r;
    awaddr_nxt  = awaddr_r;
    w_held_nxt  = w_held_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      case (awaddr_r)
        lti_pkg::CFG_OFS, lti_pkg::HIGH_LIM_OFS, lti_pkg::LOW_LIM_OFS,
        lti_pkg::ALERT_OFS, lti_pkg::IRQ_CLR_OFS, lti_pkg::IRQ_EN_OFS:
          bresp_nxt = lti_pkg::RESP_OKAY;
        default:
          bresp_nxt = lti_pkg::RESP_SLVERR;
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
    wready_nxt  = ~w_held_nxt & ~bvalid_nxt;
    // Read side
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = 32'h0000_0000;
      rresp_nxt  = lti_pkg::RESP_OKAY;
      case (s_axi_araddr)
        lti_pkg::CFG_OFS:      rdata_nxt[15:0] = cfg_view;
        lti_pkg::HIGH_LIM_OFS: rdata_nxt[15:0] = high_r;
        lti_pkg::LOW_LIM_OFS:  rdata_nxt[15:0] = low_r;
        lti_pkg::IRQ_STAT_OFS: rdata_nxt[2:0]  = stat_r;
        lti_pkg::IRQ_EN_OFS:   rdata_nxt[2:0]  = en_r;
        lti_pkg::RESULT_OFS:   rdata_nxt[15:0] = result_r;
        // Write-only registers read as zero
        lti_pkg::ALERT_OFS, lti_pkg::IRQ_CLR_OFS: rdata_nxt = 32'h0000_0000;
        default:               rresp_nxt = lti_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = ~rvalid_nxt;
  end

  // State registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fc_r      <= lti_pkg::FC_RST;
      sense_r   <= lti_pkg::SENSE_RST;
      latch_r   <= lti_pkg::LATCH_RST;
      mode_r    <= lti_pkg::MODE_RST;
      high_r    <= lti_pkg::HIGH_LIM_RST;
      low_r     <= lti_pkg::LOW_LIM_RST;
      result_r  <= 16'h0000;
      over_r    <= 1'b0;
      under_r   <= 1'b0;
      ready_r   <= 1'b0;
      active_r  <= 1'b0;
      pin_r     <= ~lti_pkg::SENSE_RST;
      stat_r    <= 3'h0;
      en_r      <= lti_pkg::IRQ_EN_RST;
      irq_r     <= 1'b0;
      aw_held_r <= 1'b0;
      awaddr_r  <= 8'h00;
      w_held_r  <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= lti_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= lti_pkg::RESP_OKAY;
    end else begin
      fc_r      <= fc_nxt;
      sense_r   <= sense_nxt;
      latch_r   <= latch_nxt;
      mode_r    <= mode_nxt;
      high_r    <= high_nxt;
      low_r     <= low_nxt;
      result_r  <= result_nxt;
      over_r    <= over_nxt;
      under_r   <= under_nxt;
      ready_r   <= ready_nxt;
      active_r  <= active_nxt;
      pin_r     <= pin_nxt;
      stat_r    <= stat_nxt;
      en_r      <= en_nxt;
      irq_r     <= irq_nxt;
      aw_held_r <= aw_held_nxt;
      awaddr_r  <= awaddr_nxt;
      w_held_r  <= w_held_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign int_pin       = pin_r;
  assign op_mode       = mode_r;
  assign irq           = irq_r;

endmodule

// [tb/lti_core_props.sv]
// Handshake and pin-cause checks bound to the threshold core
`timescale 1ns/1ps
module lti_core_props (
  // Clock, reset and conversion strobe
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        conv_done,
  // Write channel handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channel handshakes
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Sensor side outputs
  input wire logic        int_pin,
  input wire logic [1:0]  op_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Address and data taken at one edge
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read address taken
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Write answer two edges on, read answer one edge on
  wr_resp_a: assert property (wr_both |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response timing wrong");
  rd_resp_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("read response timing wrong");
  // Answers stand until taken
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  // No new request accepted while an answer is pending
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  // Pin moves only after a conversion, a write or a read
  pin_cause_a: assert property ($changed(int_pin) |-> $past(conv_done) ||
    $rose(s_axi_bvalid) || $past(s_axi_arvalid && s_axi_arready))
    else $error("pin changed without cause");
  mode_cause_a: assert property ($changed(op_mode) |-> $rose(s_axi_bvalid))
    else $error("mode changed without write");
endmodule
bind lti_core lti_core_props i_lti_core_props (.*);

// [tb/lti_host.sv]
// Register bus host model driving the core's AXI4-Lite slave
`timescale 1ns/1ps
module lti_host (
  // Clock
  input  wire logic   clk,
  // Write address and data
  output logic        s_axi_awvalid,
  input  wire logic   s_axi_awready,
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_wvalid,
  input  wire logic   s_axi_wready,
  output logic [31:0] s_axi_wdata,
  // Write response
  input  wire logic   s_axi_bvalid,
  output logic        s_axi_bready,
  // Read channels
  output logic        s_axi_arvalid,
  input  wire logic   s_axi_arready,
  output logic [7:0]  s_axi_araddr,
  input  wire logic   s_axi_rvalid,
  output logic        s_axi_rready
);
  // Idle bus, payload parked on a non-zero pattern
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = {16'hA5A5, 32'h5A5A_A5A5};
  end
  // Write: both offered together, each released once taken, either order
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    // Late ready now and then, so the answer must stand while it waits
    repeat ($urandom_range(2)) @(posedge clk);
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    {s_axi_awaddr, s_axi_wdata} <= {~a, ~d};
  endtask
  // Read: rready raised after a random wait, held until rvalid is seen
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {s_axi_arvalid, s_axi_araddr} <= {1'b1, a};
    do @(posedge clk); while (!s_axi_arready);
    {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
    repeat ($urandom_range(2)) @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
endmodule

// [tb/lti_core_tb.sv]
// Self-checking bench for the threshold interrupt core
`timescale 1ns/1ps
module lti_core_tb;
  // Clock, reset and conversion inputs
  logic        clk, sys_rst, conv_done;
  logic [15:0] conv_result;
  // Bus wires; byte lanes all enabled except for the last write, which uses lane 0 only
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, op_mode;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, int_pin, irq;
  int          mismatches, n_compared;
  logic [65:0] expq[$];  // Expected read {resp, mask, data}, oldest first
  logic [1:0]  bq[$];    // Expected write responses, oldest first
  localparam logic [7:0] CF = lti_pkg::CFG_OFS, AL = lti_pkg::ALERT_OFS;
  localparam logic [7:0] HI = lti_pkg::HIGH_LIM_OFS, LO = lti_pkg::LOW_LIM_OFS;
  localparam logic [7:0] EN = lti_pkg::IRQ_EN_OFS, CL = lti_pkg::IRQ_CLR_OFS;
  lti_core i_lti_core (.*);
  lti_host u_host (.*);
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Pin level once the edge's updates have landed
  task automatic pc(input logic lvl);
    #1;
    chk({31'h0, int_pin}, {31'h0, lvl});
  endtask
  // One conversion pulse; result line scrambled afterwards
  task automatic cv(input logic [15:0] r);
    @(posedge clk);
    {conv_done, conv_result} <= {1'b1, r};
    @(posedge clk);
    {conv_done, conv_result} <= {1'b0, ~r};
  endtask
  // Read with its expectation noted first
  task automatic rdx(input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m = 32'hFFFF_FFFF, input logic [1:0] r = 2'h0);
    expq.push_back({r, m, e});
    u_host.rd(a);
  endtask
  // Write with its expected response noted first
  task automatic wrx(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = 2'h0);
    bq.push_back(r);
    u_host.wr(a, d);
  endtask
  // Verdict and end of run
  task automatic final_report;
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Monitor takes the oldest note at each read or write answer
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready && expq.size() > 0) begin
      chk(s_axi_rdata & expq[0][63:32], expq[0][31:0]);
      chk({30'h0, s_axi_rresp}, {30'h0, expq[0][65:64]});
      void'(expq.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
      chk({30'h0, s_axi_bresp}, {30'h0, bq[0]});
      void'(bq.pop_front());
    end
  end
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end
  // Main sequence
  initial begin
    {sys_rst, conv_done, conv_result} = {2'h2, 16'h0000};
    {mismatches, n_compared} = {32'd0, 32'd0};
    void'($urandom(32'h616a1d72));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rdx(CF, 32'h0010);
    rdx(HI, 32'hFFFF);
    rdx(8'h20, 32'h0, 32'h0, lti_pkg::RESP_SLVERR);
    wrx(8'h24, 32'h0, lti_pkg::RESP_SLVERR);
    wrx(HI, 32'h8000);
    u_host.wr(LO, 32'h1000);
    u_host.wr(CF, 32'h0200);
    pc(1'b1);
    chk({30'h0, op_mode}, 32'h1);
    u_host.wr(EN, 32'h1);
    cv(16'h9000);
    pc(1'b0);
    chk({31'h0, irq}, 32'h1);
    rdx(CF, 32'h02C0);
    pc(1'b0);
    rdx(CF, 32'h0240);
    u_host.wr(AL, 32'h0);
    pc(1'b0);
    u_host.wr(CL, 32'h7);
    u_host.wr(EN, 32'h0);
    cv(16'h0800);
    pc(1'b1);
    chk({31'h0, irq}, 32'h0);
    rdx(lti_pkg::RESULT_OFS, 32'h0800);
    rdx(lti_pkg::IRQ_STAT_OFS, 32'h0005);
    rdx(CF, 32'h02A0);
    u_host.wr(CF, 32'h0201);
    cv(16'h9000);
    cv(16'($urandom_range(32'h8000, 32'h1000)));
    cv(16'h9000);
    pc(1'b1);
    cv(16'h9000);
    pc(1'b0);
    rdx(CF, 32'h02C1);
    u_host.wr(HI, 32'hFFFF);
    u_host.wr(LO, 32'hC000);
    u_host.wr(CF, 32'h0210);
    cv(16'hD000);
    pc(1'b0);
    rdx(CF, 32'h0290, 32'hFFFF_FF9F);
    pc(1'b1);
    cv(16'h0100);
    u_host.wr(AL, 32'h0);
    pc(1'b1);
    rdx(CF, 32'h02B0);
    cv(16'hD000);
    rdx(CF, 32'h0290);
    cv(16'hD000);
    u_host.wr(CF, 32'h0010);
    pc(1'b0);
    rdx(CF, 32'h0090);
    cv(16'hD000);
    u_host.wr(LO, 32'h1000);
    u_host.wr(CF, 32'h0200);
    pc(1'b1);
    u_host.wr(LO, 32'hC000);
    cv(16'h0100);
    u_host.wr(AL, 32'h0);
    pc(1'b0);
    rdx(CF, 32'h02A0);
    pc(1'b1);
    cv(16'hD000);
    u_host.wr(CF, 32'h0200);
    pc(1'b1);
    rdx(CF, 32'h0220);
    @(posedge clk) s_axi_wstrb <= 4'h1;
    u_host.wr(CF, 32'h0008);
    chk({30'h0, op_mode}, 32'h1);
    pc(1'b0);
    cv(16'hD000);
    pc(1'b1);
    final_report();
  end
endmodule
